// [hdl/fsol_defines.vh]
`ifndef FSOL_DEFINES_VH
`define FSOL_DEFINES_VH

// Register indices; the APB byte address is four times the index.
`define FSOL_IDX_CLKDIV   16'h1820
`define FSOL_IDX_OPTW     16'h1821
`define FSOL_IDX_CFG      16'h1823
`define FSOL_IDX_PROTW    16'h1824
`define FSOL_IDX_STAT     16'h1825
`define FSOL_IDX_CMD      16'h1826
`define FSOL_IDX_KEYIN    16'h1830
`define FSOL_IDX_SECST    16'h1831
`define FSOL_IDX_TRIMLO   16'hFFAD
`define FSOL_IDX_TRIMHI   16'hFFAE
`define FSOL_IDX_TRIMC    16'hFFAF
`define FSOL_IDX_KEY0     16'hFFB0
`define FSOL_IDX_KEY7     16'hFFB7
`define FSOL_IDX_PROTST   16'hFFBD
`define FSOL_IDX_OPTST    16'hFFBF

// Field positions.
`define FSOL_OPT_BACKDOOR_KEY_ENABLE    7
`define FSOL_CFG_KEYACC   5
`define FSOL_DIV_LOADED   7
`define FSOL_SS_KEYFAIL   3
`define FSOL_SS_KEYREJ    4
`define FSOL_SS_RAMBLK    5
`define FSOL_SS_RAMUNDEF  6

// Values.
`define FSOL_SEC_OPEN     2'h2
`define FSOL_STAT_IDLE    8'hC0
`define FSOL_CFG_MASK     8'h20
`define FSOL_KEY_LAST     4'h7
`define FSOL_RAM_AW       8

`endif

// [hdl/fsol_ram.v]
`timescale 1ns/10ps

module fsol_ram (
  input  wire       clk,    // Bus clock.
  input  wire       rd,     // Read strobe.
  input  wire       wr,     // Write strobe.
  input  wire       clr,    // Zero the read register.
  input  wire [7:0] addr,   // Byte address.
  input  wire [7:0] wdata,  // Write data.
  output reg  [7:0] rdata   // Registered read data.
);

  // No reset on the array: contents ride through every reset.
  reg [7:0] mem [0:255];

  always @(posedge clk) begin
    if (wr) begin
      mem[addr] <= wdata;
    end
    if (rd) begin
      rdata <= mem[addr];
    end else if (clr) begin
      rdata <= 8'h00;
    end
  end

endmodule // fsol_ram

// [hdl/fsol_top.v]
`timescale 1ns/10ps
`include "fsol_defines.vh"

// Behaviour
// [R1] Reset copies stored protection and option bytes
// [R2] Key unsecures only while key enable is 1
// [R3] Key accepted only from secure code, not debug
// [R4] Key enable 0 disables key compare entirely
// [R5] Otherwise only verified mass erase unsecures
// [R6] Security code 1:0 means unsecured
// [R7] Secure: block debug and non-secure RAM access
// [R8] RAM retained in wait and lighter stops
// [R9] Power-on or deepest stop wake: RAM undefined
// [R10] Reset never alters RAM contents
// [R11] Fine trim bit 0, coarse trim next byte
// [R12] Flash array is eight 512-byte pages
// [R13] Stored bytes change only by flash procedures
// [R14] Any other security code is secure; reevaluated
module fsol_top (
  input  wire        pclk,               // Bus clock.
  input  wire        presetn,            // Async reset, active low.
  input  wire [17:0] paddr,              // APB byte address.
  input  wire        psel,               // APB select.
  input  wire        penable,            // APB access phase.
  input  wire        pwrite,             // APB write.
  input  wire [31:0] pwdata,             // APB write data.
  output reg  [31:0] prdata,             // APB read data.
  output wire        pready,             // APB ready.
  output wire        pslverr,            // APB error on unmapped index.
  input  wire [7:0]  nv_prot_in,         // Stored protection byte.
  input  wire [7:0]  nv_opt_in,          // Stored option byte.
  input  wire [63:0] nv_key_in,          // Stored key, first byte in [63:56].
  input  wire [7:0]  nv_trim_low_in,     // Temperature sensor trim low.
  input  wire [7:0]  nv_trim_high_in,    // Sensor trim high and fine trim.
  input  wire [7:0]  nv_trim_coarse_in,  // Coarse clock trim.
  input  wire        exec_in_secure_mem, // Bus master runs from secure memory.
  input  wire        access_from_debug,  // Bus access comes from debug path.
  input  wire        erase_blank_ok,     // Pulse: mass erase verified blank.
  input  wire        por_pin,            // Power-on indication, asynchronous.
  input  wire        deepest_stop_wake,  // Pulse: wakeup from deepest stop.
  input  wire        ram_req,            // RAM access request.
  input  wire        ram_we,             // RAM write.
  input  wire [7:0]  ram_addr,           // RAM address.
  input  wire [7:0]  ram_wdata,          // RAM write data.
  input  wire        ram_from_debug,     // RAM access via debug path.
  input  wire        ram_from_nonsecure, // RAM access by non-secure code.
  output wire [7:0]  ram_rdata,          // RAM read data.
  output reg         ram_ack,            // Pulse: RAM access done.
  output reg         ram_blocked,        // Pulse: RAM access refused.
  output reg         secured,            // Device is secure.
  output reg  [7:0]  block_protection,   // Working protection byte.
  output reg         fine_clock_trim_bit,// Fine clock trim.
  output reg  [7:0]  coarse_clock_trim   // Coarse clock trim.
);

  localparam ST_LOAD = 1'b0;
  localparam ST_RUN  = 1'b1;

  localparam [12:0] PAGE_BYTES  = 13'd512;
  localparam [3:0]  PAGE_COUNT  = 4'd8;
  localparam [12:0] FLASH_BYTES = 13'd4096;

  reg        state_reg;
  reg        state_next;
  reg        por_s1_reg;
  reg        por_s2_reg;
  reg [7:0]  option_reg;
  reg [7:0]  clkdiv_reg;
  reg        cfg_keyacc_reg;
  reg [7:0]  cmd_reg;
  reg [55:0] key_shift_reg;
  reg [3:0]  key_cnt_reg;
  reg        unsec_key_reg;
  reg        unsec_erase_reg;
  reg        key_fail_reg;
  reg        key_rej_reg;
  reg        ram_blk_seen_reg;
  reg        ram_undef_reg;

  wire [15:0] idx;
  wire        setup;
  wire        wr_acc;
  wire        key_wr;
  wire        key_ok;
  wire        key_done;
  wire        key_match;
  wire        w1c_fail;
  wire        w1c_rej;
  wire        w1c_blk;
  wire        w1c_undef;
  wire        ram_deny;
  wire        ram_go;
  wire        secure_code;

  // Flash array geometry, shown in the upper half of the security status word.
  wire [12:0] flash_size = PAGE_BYTES * {9'd0, PAGE_COUNT}; // [R12]

  function mapped;
    input [15:0] i;
    begin
      mapped = (i == `FSOL_IDX_CLKDIV) || (i == `FSOL_IDX_OPTW) ||
               (i == `FSOL_IDX_CFG) || (i == `FSOL_IDX_PROTW) ||
               (i == `FSOL_IDX_STAT) || (i == `FSOL_IDX_CMD) ||
               (i == `FSOL_IDX_KEYIN) || (i == `FSOL_IDX_SECST) ||
               (i >= `FSOL_IDX_TRIMLO && i <= `FSOL_IDX_KEY7) ||
               (i == `FSOL_IDX_PROTST) || (i == `FSOL_IDX_OPTST);
    end
  endfunction

  function [7:0] key_byte;
    input [63:0] k;
    input [2:0]  n;
    begin
      key_byte = k[8'd63 - {n, 3'b000} -: 8];
    end
  endfunction

  // Register write strobe for one index in the access phase.
  function reg_wr;
    input        acc;
    input [15:0] i;
    input [15:0] target;
    begin
      reg_wr = acc && (i == target);
    end
  endfunction

  // Security decode shared by the load cycle and the running state.
  function code_secure;
    input [1:0] c;
    begin
      code_secure = (c != `FSOL_SEC_OPEN);
    end
  endfunction

  assign idx    = paddr[17:2];
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite && (state_reg == ST_RUN);

  // Reads never leave the bus hanging once the load is done.
  assign pready  = (state_reg == ST_RUN);
  // Writes to an unmapped index change nothing; the error only informs software.
  assign pslverr = psel && penable && pready && !mapped(idx);

  // Any code other than the open one is secure; the erase and key
  // escapes last only until the next reset reloads the option byte.
  assign secure_code = code_secure(option_reg[1:0]); // [R6] [R14]

  // Only secure-resident code may feed the key, never the debug path.
  assign key_wr = reg_wr(wr_acc, idx, `FSOL_IDX_KEYIN);
  assign key_ok = key_wr && cfg_keyacc_reg && exec_in_secure_mem &&
                  !access_from_debug && option_reg[`FSOL_OPT_BACKDOOR_KEY_ENABLE]; // [R2] [R3] [R4]
  assign key_done  = key_ok && (key_cnt_reg == `FSOL_KEY_LAST);
  assign key_match = ({key_shift_reg, pwdata[7:0]} == nv_key_in);

  assign w1c_fail  = reg_wr(wr_acc, idx, `FSOL_IDX_SECST) && pwdata[`FSOL_SS_KEYFAIL];
  assign w1c_rej   = reg_wr(wr_acc, idx, `FSOL_IDX_SECST) && pwdata[`FSOL_SS_KEYREJ];
  assign w1c_blk   = reg_wr(wr_acc, idx, `FSOL_IDX_SECST) && pwdata[`FSOL_SS_RAMBLK];
  assign w1c_undef = reg_wr(wr_acc, idx, `FSOL_IDX_SECST) && pwdata[`FSOL_SS_RAMUNDEF];

  assign ram_deny = ram_req && secured && (ram_from_debug || ram_from_nonsecure); // [R7]
  assign ram_go   = ram_req && !ram_deny;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_LOAD: state_next = ST_RUN;
      ST_RUN:  state_next = ST_RUN;
      default: state_next = ST_LOAD;
    endcase
  end

  // The power-on pin is asynchronous and is only ever sampled here.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_s1_reg <= 1'b0;
      por_s2_reg <= 1'b0;
    end else begin
      por_s1_reg <= por_pin;
      por_s2_reg <= por_s1_reg;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg           <= ST_LOAD;
      option_reg          <= 8'h00;
      block_protection    <= 8'h00;
      fine_clock_trim_bit <= 1'b0;
      coarse_clock_trim   <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_LOAD) begin
        option_reg          <= nv_opt_in;                  // [R1]
        block_protection    <= nv_prot_in;                 // [R1]
        fine_clock_trim_bit <= nv_trim_high_in[0];         // [R11]
        coarse_clock_trim   <= nv_trim_coarse_in;          // [R11]
      end else if (reg_wr(wr_acc, idx, `FSOL_IDX_PROTW)) begin
        block_protection <= pwdata[7:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clkdiv_reg     <= 8'h00;
      cfg_keyacc_reg <= 1'b0;
      cmd_reg        <= 8'h00;
    end else begin
      // The divider takes one write per reset; later writes are dropped.
      if (reg_wr(wr_acc, idx, `FSOL_IDX_CLKDIV) && !clkdiv_reg[`FSOL_DIV_LOADED]) begin
        clkdiv_reg <= {1'b1, pwdata[6:0]};
      end
      if (reg_wr(wr_acc, idx, `FSOL_IDX_CFG)) begin
        cfg_keyacc_reg <= pwdata[`FSOL_CFG_KEYACC];
      end
      if (reg_wr(wr_acc, idx, `FSOL_IDX_CMD)) begin
        cmd_reg <= pwdata[7:0];
      end
    end
  end

  // Key bytes arrive first-stored-byte first; the eighth byte compares.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_shift_reg <= 56'h00000000000000;
      key_cnt_reg   <= 4'h0;
      unsec_key_reg <= 1'b0;
      key_fail_reg  <= 1'b0;
      key_rej_reg   <= 1'b0;
    end else begin
      if (key_done) begin
        key_cnt_reg   <= 4'h0;
        key_shift_reg <= 56'h00000000000000;
      end else if (key_ok) begin
        key_cnt_reg   <= key_cnt_reg + 4'h1;
        key_shift_reg <= {key_shift_reg[47:0], pwdata[7:0]};
      end
      if (key_done && key_match) begin
        unsec_key_reg <= 1'b1;                             // [R2]
      end
      if (key_done && !key_match) begin
        key_fail_reg <= 1'b1;
      end else if (w1c_fail) begin
        key_fail_reg <= 1'b0;
      end
      if (key_wr && !key_ok) begin
        key_rej_reg <= 1'b1;                               // [R3] [R4]
      end else if (w1c_rej) begin
        key_rej_reg <= 1'b0;
      end
    end
  end

  // With the key disabled, the verified blank array is the only way out.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unsec_erase_reg <= 1'b0;
      secured         <= 1'b1;
    end else begin
      if (erase_blank_ok && state_reg == ST_RUN) begin
        unsec_erase_reg <= 1'b1;                           // [R5]
      end
      // The load cycle decodes the stored byte directly, since the working
      // copy only takes it at this same edge.
      secured <= (state_reg == ST_LOAD) ? code_secure(nv_opt_in[1:0]) :
                 (secure_code && !unsec_key_reg && !unsec_erase_reg); // [R14]
    end
  end

  // The array keeps its data through wait and the lighter stops since
  // nothing here powers it down; only the flag tracks lost contents.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_ack          <= 1'b0;
      ram_blocked      <= 1'b0;
      ram_blk_seen_reg <= 1'b0;
      ram_undef_reg    <= 1'b0;
    end else begin
      ram_ack     <= ram_go;                               // [R8]
      ram_blocked <= ram_deny;                             // [R7]
      if (ram_deny) begin
        ram_blk_seen_reg <= 1'b1;
      end else if (w1c_blk) begin
        ram_blk_seen_reg <= 1'b0;
      end
      // The synchroniser is held clear during reset, so the power-on level is
      // taken whenever it shows; software clears the flag once the pin drops.
      if (deepest_stop_wake || por_s2_reg) begin
        ram_undef_reg <= 1'b1;                             // [R9]
      end else if (w1c_undef) begin
        ram_undef_reg <= 1'b0;
      end
    end
  end

  // Read data is latched in the setup phase so it is ready at access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= 32'h00000000;
      case (idx)
        `FSOL_IDX_CLKDIV: prdata[7:0] <= clkdiv_reg;
        `FSOL_IDX_OPTW:   prdata[7:0] <= option_reg;
        `FSOL_IDX_CFG:    prdata[7:0] <= {2'b00, cfg_keyacc_reg, 5'b00000};
        `FSOL_IDX_PROTW:  prdata[7:0] <= block_protection;
        `FSOL_IDX_STAT:   prdata[7:0] <= `FSOL_STAT_IDLE;
        `FSOL_IDX_CMD:    prdata[7:0] <= cmd_reg;
        `FSOL_IDX_SECST: begin
          prdata[11:0]  <= {key_cnt_reg, 1'b0, ram_undef_reg,
                            ram_blk_seen_reg, key_rej_reg,
                            key_fail_reg, unsec_erase_reg,
                            unsec_key_reg, secured};
          prdata[28:16] <= flash_size;                     // [R12]
        end
        `FSOL_IDX_TRIMLO: prdata[7:0] <= nv_trim_low_in;
        `FSOL_IDX_TRIMHI: prdata[7:0] <= nv_trim_high_in;
        `FSOL_IDX_TRIMC:  prdata[7:0] <= nv_trim_coarse_in;
        `FSOL_IDX_PROTST: prdata[7:0] <= nv_prot_in;
        `FSOL_IDX_OPTST:  prdata[7:0] <= nv_opt_in;
        default: begin
          if (idx >= `FSOL_IDX_KEY0 && idx <= `FSOL_IDX_KEY7) begin
            prdata[7:0] <= key_byte(nv_key_in, idx[2:0]);
          end
        end
      endcase
    end
  end

  // The array has no reset path, so reset leaves its contents alone.
  fsol_ram u_ram (                                         // [R10]
    .clk   (pclk),
    .rd    (ram_go && !ram_we),
    .wr    (ram_go && ram_we),
    .clr   (ram_deny),
    .addr  (ram_addr),
    .wdata (ram_wdata),
    .rdata (ram_rdata)
  );

endmodule // fsol_top

// [testbench/fsol_props.sv]
`timescale 1ns/10ps
`include "fsol_defines.vh"

module fsol_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [17:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  nv_prot_in,
  input wire logic [7:0]  nv_opt_in,
  input wire logic        access_from_debug,
  input wire logic        erase_blank_ok,
  input wire logic        ram_req,
  input wire logic        ram_from_debug,
  input wire logic        ram_from_nonsecure,
  input wire logic [7:0]  ram_rdata,
  input wire logic        ram_ack,
  input wire logic        ram_blocked,
  input wire logic        secured,
  input wire logic [7:0]  block_protection
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Only the single load cycle after release may stall the bus.
  property p_ready; presetn && $past(presetn) |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low after load");
  property p_err_phase; pslverr |-> psel && penable; endproperty
  a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
  property p_unmapped; psel && penable && paddr[17:2] == 16'h1822 |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped index accepted");
  property p_prot_load;
    presetn && !$past(presetn) |=> block_protection == $past(nv_prot_in);
  endproperty
  a_prot_load: assert property (p_prot_load) else $error("protection not loaded");
  property p_sec_load;
    presetn && !$past(presetn) |=> secured == (($past(nv_opt_in) & 8'h03) != 8'h02);
  endproperty
  a_sec_load: assert property (p_sec_load) else $error("security not loaded");
  property p_ram_block;
    ram_req && secured && (ram_from_debug || ram_from_nonsecure)
      |=> ram_blocked && !ram_ack && ram_rdata == 8'h00;
  endproperty
  a_ram_block: assert property (p_ram_block) else $error("RAM not blocked");
  property p_ram_ok; ram_req && !secured |=> ram_ack && !ram_blocked; endproperty
  a_ram_ok: assert property (p_ram_ok) else $error("RAM access refused");
  property p_erase; presetn && $past(presetn) && erase_blank_ok |-> ##[1:2] !secured; endproperty
  a_erase: assert property (p_erase) else $error("erase did not unsecure");
  property p_key_dbg;
    psel && penable && pready && pwrite && paddr[17:2] == `FSOL_IDX_KEYIN
      && access_from_debug && secured |=> secured;
  endproperty
  a_key_dbg: assert property (p_key_dbg) else $error("debug key unsecured");
endmodule // fsol_props

bind fsol_top fsol_props i_fsol_props (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pready, .pslverr, .nv_prot_in, .nv_opt_in, .access_from_debug, .erase_blank_ok, .ram_req,
  .ram_from_debug, .ram_from_nonsecure, .ram_rdata, .ram_ack, .ram_blocked, .secured,
  .block_protection);

// [testbench/tb_top.sv]
`timescale 1ns/10ps
`include "fsol_defines.vh"
`define CHK(x, y) begin check_count++; if ((x) !== (y)) begin mismatches++; \
  $display("BAD t=%0t got %h exp %h", $time, (x), (y)); end end

module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, exec_in_secure_mem, access_from_debug;
  logic        erase_blank_ok, por_pin, deepest_stop_wake, ram_req, ram_we;
  logic        ram_from_debug, ram_from_nonsecure, err, blk;
  logic [17:0] paddr;
  logic [31:0] pwdata, rd;
  logic [7:0]  nv_prot_in, nv_opt_in, nv_trim_low_in, nv_trim_high_in, nv_trim_coarse_in;
  logic [7:0]  ram_addr, ram_wdata;
  logic [63:0] nv_key_in;
  wire  [31:0] prdata;
  wire  [7:0]  ram_rdata, block_protection, coarse_clock_trim;
  wire         pready, pslverr, ram_ack, ram_blocked, secured, fine_clock_trim_bit;
  int          mismatches, check_count;
  bit          exp_sec;
  logic [7:0]  mem_model [0:255];

  fsol_top i_fsol_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .nv_prot_in, .nv_opt_in, .nv_key_in, .nv_trim_low_in, .nv_trim_high_in,
    .nv_trim_coarse_in, .exec_in_secure_mem, .access_from_debug, .erase_blank_ok, .por_pin,
    .deepest_stop_wake, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_from_debug,
    .ram_from_nonsecure, .ram_rdata, .ram_ack, .ram_blocked, .secured, .block_protection,
    .fine_clock_trim_bit, .coarse_clock_trim);

  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic apb(input bit wr, input [15:0] idx, input [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= {idx, 2'b00};
    pwdata <= {24'($urandom), wd};
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin mismatches++; conclude; end
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  // Stored bytes change only while reset is held, as a flash update would between resets.
  task automatic do_reset(input [7:0] opt);
    presetn <= 0;
    nv_opt_in <= opt; nv_prot_in <= 8'($urandom); nv_key_in <= {$urandom, $urandom};
    nv_trim_low_in <= 8'($urandom); nv_trim_high_in <= 8'($urandom);
    nv_trim_coarse_in <= 8'($urandom);
    repeat (10) @(posedge pclk);
    presetn <= 1;
    exp_sec = opt[1:0] != 2'b10;
  endtask

  task automatic ram(input bit we, input [7:0] a, input [7:0] d, input bit dg, input bit ns);
    @(posedge pclk);
    ram_req <= 1; ram_we <= we; ram_addr <= a; ram_wdata <= d;
    ram_from_debug <= dg; ram_from_nonsecure <= ns;
    @(posedge pclk);
    ram_req <= 0;
    @(posedge pclk);
    blk = exp_sec && (dg || ns);
    `CHK(ram_blocked, blk)
    `CHK(ram_ack, !blk)
    if (!blk && we) mem_model[a] = d;
    if (!we) `CHK(ram_rdata, blk ? 8'h00 : mem_model[a])
  endtask

  task automatic key_in(input [63:0] k);
    for (int i = 0; i < 8; i++) apb(1, `FSOL_IDX_KEYIN, k[63-8*i -: 8]);
  endtask

  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    exec_in_secure_mem = 1; access_from_debug = 0; erase_blank_ok = 0; por_pin = 1;
    deepest_stop_wake = 0; ram_req = 0; ram_we = 0; ram_addr = 0; ram_wdata = 0;
    ram_from_debug = 0; ram_from_nonsecure = 0;
    rd = $urandom(32'hB222);
    do_reset(8'h83);
    repeat (3) @(posedge pclk);
    por_pin <= 0;
    apb(0, `FSOL_IDX_OPTW, 0); `CHK(rd, {24'h0, nv_opt_in})
    apb(0, `FSOL_IDX_PROTW, 0); `CHK(rd, {24'h0, nv_prot_in})
    `CHK(block_protection, nv_prot_in)
    apb(0, `FSOL_IDX_TRIMHI, 0); `CHK(rd, {24'h0, nv_trim_high_in})
    apb(0, `FSOL_IDX_TRIMC, 0); `CHK(rd, {24'h0, nv_trim_coarse_in})
    `CHK(fine_clock_trim_bit, nv_trim_high_in[0])
    `CHK(coarse_clock_trim, nv_trim_coarse_in)
    for (int i = 0; i < 8; i++) begin
      apb(0, `FSOL_IDX_KEY0 + 16'(i), 0); `CHK(rd[7:0], nv_key_in[63-8*i -: 8])
    end
    apb(1, `FSOL_IDX_OPTST, 8'h02); apb(0, `FSOL_IDX_OPTST, 0); `CHK(rd, {24'h0, nv_opt_in})
    apb(0, 16'h1822, 0); `CHK(err, 1'b1)
    apb(0, `FSOL_IDX_SECST, 0); `CHK(rd[6], 1'b1)
    `CHK(rd[28:16], 13'h1000)
    `CHK(secured, 1'b1)
    ram(1, 8'h10, 8'h5A, 1, 0); ram(0, 8'h10, 0, 0, 1); ram(1, 8'h10, 8'($urandom), 0, 0);
    ram(0, 8'h10, 0, 0, 0);
    $display("test load and ram done");
    apb(1, `FSOL_IDX_CFG, `FSOL_CFG_MASK);
    key_in(~nv_key_in);
    apb(0, `FSOL_IDX_SECST, 0); `CHK(rd[3], 1'b1)
    for (int j = 0; j < 2; j++) begin
      exec_in_secure_mem <= j[0]; access_from_debug <= j[0];
      key_in(nv_key_in);
      apb(0, `FSOL_IDX_SECST, 0); `CHK(rd[4], 1'b1)
      `CHK(secured, 1'b1)
    end
    exec_in_secure_mem <= 1; access_from_debug <= 0;
    key_in(nv_key_in);
    apb(0, `FSOL_IDX_SECST, 0); `CHK(secured, 1'b0)
    exp_sec = 0;
    ram(1, 8'hFF, 8'($urandom), 1, 0); ram(0, 8'hFF, 0, 1, 1);
    $display("test key done");
    do_reset(8'h03);
    ram(0, 8'hFF, 0, 0, 0);
    apb(1, `FSOL_IDX_CFG, `FSOL_CFG_MASK);
    key_in(nv_key_in);
    apb(0, `FSOL_IDX_SECST, 0); `CHK(rd[4], 1'b1)
    `CHK(secured, 1'b1)
    @(posedge pclk) erase_blank_ok <= 1;
    @(posedge pclk) erase_blank_ok <= 0;
    repeat (2) @(posedge pclk);
    `CHK(secured, 1'b0)
    $display("test disabled key and erase done");
    do_reset(8'h82);
    repeat (3) @(posedge pclk);
    `CHK(secured, 1'b0)
    apb(1, `FSOL_IDX_CLKDIV, 8'h05); apb(1, `FSOL_IDX_CLKDIV, 8'h0A);
    apb(0, `FSOL_IDX_CLKDIV, 0); `CHK(rd, 32'h00000085)
    @(posedge pclk) deepest_stop_wake <= 1;
    @(posedge pclk) deepest_stop_wake <= 0;
    apb(0, `FSOL_IDX_SECST, 0); `CHK(rd[6], 1'b1)
    apb(0, `FSOL_IDX_STAT, 0); `CHK(rd, {24'h0, `FSOL_STAT_IDLE})
    $display("test open code done");
    conclude;
  end
endmodule // tb_top
